// *** design/gpt_sysctl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gpt_defines.svh"

// Notes on behaviour
// - Timer runs while its enable bit is one, halts at zero; enable resets 0.
// - Enable falling from one to zero forces the preload field to FFFFh.
// - Read/write 16-bit preload, reset FFFFh, is loaded into the timer.
// - Read-only current count shows the live timer value, reset FFFFh.
// - Timer raises interrupt events at intervals set by its configuration.
// - Swap value not all ones: A[1]=1 selects upper half, A[1]=0 lower.
// - Swap value all ones reverses the mapping: A[1]=1 selects lower half.
// - Network side always sends/receives the lower half-word first, unswapped.
// - Read-only 32-bit free counter starts at zero, steps every 25MHz cycle.
// - Free counter wraps from maximum to zero and keeps counting.
// - First half-word read captures the whole free count coherently.
// - Free counter may take 160ns to clear after reset; host waits.
// - Free counter keeps running in every power management state.
module gpt_sysctl #(
    parameter int TICK_DIV = `GPT_TICK_DIV
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        host_cs_n,
    input  wire logic        host_rd_n,
    input  wire logic        host_wr_n,
    input  wire logic [7:1]  host_addr,
    input  wire logic [15:0] host_data_in,
    output logic      [15:0] host_data_out,
    output logic             host_data_oe,
    output logic             timer_expired,
    output logic             timer_running,
    output logic             half_swap_active
);

    localparam int FREE_DIV = `GPT_FREE_DIV;
    localparam int DW       = (FREE_DIV > 1) ? $clog2(FREE_DIV) : 1;

    // Host strobe tracking
    logic        cs_rd;
    logic        cs_wr;
    logic        rd_seen;
    logic        wr_seen;
    logic        rd_start;
    logic        wr_start;
    logic [7:0]  byte_addr;
    logic        sel_upper;

    // Software visible state
    logic        timer_enable;
    logic [15:0] timer_preload;
    logic [31:0] swap_word;
    logic        next_timer_enable;
    logic [15:0] next_timer_preload;
    logic [31:0] next_swap_word;

    // Free-running count and its capture
    logic [DW-1:0]        div_cnt;
    logic [DW-1:0]        next_div_cnt;
    logic                 free_tick;
    logic [31:0]          free_count_value;
    logic [31:0]          next_free_count_value;
    logic [31:0]          free_latched;
    logic [31:0]          next_free_latched;
    gpt_pkg::gpt_latch_t  latch_state;
    gpt_pkg::gpt_latch_t  next_latch_state;

    // Read path
    logic [15:0] timer_current_count;
    logic [31:0] rd_word;
    logic [15:0] next_host_data_out;

    // Maps host A[1] to the internal half; shared by reads and writes
    function automatic logic upper_sel(input logic a1,
                                       input logic [31:0] swap);
        upper_sel = a1 ^ (swap == `GPT_SWAP_ALL);
    endfunction

    // Only the first cycle of a strobe acts, so a long strobe is one access
    assign cs_rd     = !host_cs_n && !host_rd_n;
    assign cs_wr     = !host_cs_n && !host_wr_n;
    assign rd_start  = cs_rd && !rd_seen;
    assign wr_start  = cs_wr && !wr_seen;
    assign byte_addr = {host_addr[7:2], 2'b00};
    assign sel_upper = upper_sel(host_addr[1], swap_word);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_seen <= 1'b0;
            wr_seen <= 1'b0;
        end else begin
            rd_seen <= cs_rd;
            wr_seen <= cs_wr;
        end
    end

    // Register writes; the forced preload is applied after the write so a
    // single write that clears enable still ends with FFFFh
    always_comb begin
        next_timer_enable  = timer_enable;
        next_timer_preload = timer_preload;
        next_swap_word     = swap_word;
        if (wr_start) begin
            if (byte_addr == `GPT_OFS_CFG) begin
                if (sel_upper) begin
                    next_timer_enable = host_data_in[`GPT_EN_HI_BIT];
                end else begin
                    next_timer_preload = host_data_in;
                end
            end else if (byte_addr == `GPT_OFS_SWAP) begin
                if (sel_upper) begin
                    next_swap_word[31:16] = host_data_in;
                end else begin
                    next_swap_word[15:0] = host_data_in;
                end
            end
        end
        if (timer_enable && !next_timer_enable) begin
            next_timer_preload = `TIMER_PRELOAD_RST;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_enable  <= 1'b0;
            timer_preload <= `TIMER_PRELOAD_RST;
            swap_word     <= `GPT_SWAP_RST;
        end else begin
            timer_enable  <= next_timer_enable;
            timer_preload <= next_timer_preload;
            swap_word     <= next_swap_word;
        end
    end

    // 25MHz enable from the core clock; no power-state input gates it
    assign free_tick = (div_cnt == DW'(FREE_DIV - 1));

    always_comb begin
        next_div_cnt          = free_tick ? '0 : div_cnt + 1'b1;
        next_free_count_value = free_count_value;
        if (free_tick) begin
            next_free_count_value = free_count_value + 32'h00000001;
        end
    end

    // Async reset clears at once, well inside the allowed window
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt          <= '0;
            free_count_value <= `GPT_FREE_RST;
        end else begin
            div_cnt          <= next_div_cnt;
            free_count_value <= next_free_count_value;
        end
    end

    // Capture on the first half read, release on the other half; reading
    // the same half twice starts a fresh capture instead of going stale
    always_comb begin
        next_latch_state  = latch_state;
        next_free_latched = free_latched;
        if (rd_start && byte_addr == `GPT_OFS_FREE) begin
            unique case (latch_state)
                gpt_pkg::GPT_LATCH_IDLE: begin
                    next_free_latched = free_count_value;
                    next_latch_state  = sel_upper ?
                        gpt_pkg::GPT_LATCH_HI_TAKEN :
                        gpt_pkg::GPT_LATCH_LO_TAKEN;
                end
                gpt_pkg::GPT_LATCH_LO_TAKEN: begin
                    if (sel_upper) begin
                        next_latch_state = gpt_pkg::GPT_LATCH_IDLE;
                    end else begin
                        next_free_latched = free_count_value;
                    end
                end
                gpt_pkg::GPT_LATCH_HI_TAKEN: begin
                    if (!sel_upper) begin
                        next_latch_state = gpt_pkg::GPT_LATCH_IDLE;
                    end else begin
                        next_free_latched = free_count_value;
                    end
                end
                default: begin
                    next_latch_state = gpt_pkg::GPT_LATCH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_state  <= gpt_pkg::GPT_LATCH_IDLE;
            free_latched <= `GPT_FREE_RST;
        end else begin
            latch_state  <= next_latch_state;
            free_latched <= next_free_latched;
        end
    end

    // Timer prescales the 25MHz enable, so its interval scales with it
    gpt_timer_core #(
        .TICK_DIV (TICK_DIV),
        .W        (16)
    ) u_timer (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .base_tick (free_tick),
        .enable    (timer_enable),
        .preload   (timer_preload),
        .count     (timer_current_count),
        .expired   (timer_expired)
    );

    // Read mux; a capture read returns the live count, which equals the
    // value being latched in that same cycle
    always_comb begin
        rd_word = 32'h00000000;
        unique case (byte_addr)
            `GPT_OFS_CFG: begin
                rd_word[`GPT_EN_BIT] = timer_enable;
                rd_word[15:0]        = timer_preload;
            end
            `GPT_OFS_CNT: begin
                rd_word[15:0] = timer_current_count;
            end
            `GPT_OFS_SWAP: begin
                rd_word = swap_word;
            end
            `GPT_OFS_FREE: begin
                if ((latch_state == gpt_pkg::GPT_LATCH_LO_TAKEN
                     && sel_upper)
                    || (latch_state == gpt_pkg::GPT_LATCH_HI_TAKEN
                        && !sel_upper)) begin
                    rd_word = free_latched;
                end else begin
                    rd_word = free_count_value;
                end
            end
            default: begin
                rd_word = 32'h00000000;  // Unmapped reads as zero
            end
        endcase
        next_host_data_out = host_data_out;
        if (rd_start) begin
            next_host_data_out = sel_upper ? rd_word[31:16]
                                           : rd_word[15:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_data_out <= 16'h0000;
        end else begin
            host_data_out <= next_host_data_out;
        end
    end

    // Bus driven for the whole read strobe; data valid from the next edge
    assign host_data_oe     = cs_rd;
    assign timer_running    = timer_enable;
    // FIFO datapath uses this for host lanes only; the network order of
    // half-words never depends on it
    assign half_swap_active = (swap_word == `GPT_SWAP_ALL);

endmodule

`default_nettype wire

// *** design/gpt_timer_core.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gpt_defines.svh"

// Down-counting interval timer with its own prescaler on the base tick
module gpt_timer_core #(
    parameter int TICK_DIV = `GPT_TICK_DIV,
    parameter int W        = 16
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         base_tick,
    input  wire logic         enable,
    input  wire logic [W-1:0] preload,
    output logic      [W-1:0] count,
    output logic              expired
);

    localparam int PW = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;

    logic [PW-1:0] pre_cnt;
    logic          en_d;
    logic [W-1:0]  next_count;
    logic [PW-1:0] next_pre_cnt;
    logic          next_en_d;
    logic          next_expired;

    // Start loads the preload; halted timer simply holds its count
    always_comb begin
        next_count   = count;
        next_pre_cnt = pre_cnt;
        next_en_d    = enable;
        next_expired = 1'b0;
        if (enable && !en_d) begin
            next_count   = preload;
            next_pre_cnt = '0;
        end else if (enable && base_tick) begin
            if (pre_cnt == PW'(TICK_DIV - 1)) begin
                next_pre_cnt = '0;
                if (count == '0) begin
                    next_expired = 1'b1;
                    next_count   = preload;
                end else begin
                    next_count = count - 1'b1;
                end
            end else begin
                next_pre_cnt = pre_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count   <= `TIMER_CURRENT_COUNT_RST;
            pre_cnt <= '0;
            en_d    <= 1'b0;
            expired <= 1'b0;
        end else begin
            count   <= next_count;
            pre_cnt <= next_pre_cnt;
            en_d    <= next_en_d;
            expired <= next_expired;
        end
    end

endmodule

`default_nettype wire

// *** include/gpt_defines.svh ***
`ifndef GPT_DEFINES_SVH
`define GPT_DEFINES_SVH

// Register byte offsets on the host bus
`define GPT_OFS_CFG        8'h8c
`define GPT_OFS_CNT        8'h90
`define GPT_OFS_SWAP       8'h98
`define GPT_OFS_FREE       8'h9c

// Field positions
`define GPT_EN_BIT         29
`define GPT_EN_HI_BIT      (`GPT_EN_BIT - 16)

// Reset values and the all-ones swap pattern
`define TIMER_PRELOAD_RST       16'hffff
`define TIMER_CURRENT_COUNT_RST        16'hffff
`define GPT_SWAP_RST       32'h00000000
`define GPT_SWAP_ALL       32'hffffffff
`define GPT_FREE_RST       32'h00000000

// Timing
`define GPT_CLK_MHZ        100
`define GPT_FREE_MHZ       25
`define GPT_FREE_DIV       (`GPT_CLK_MHZ / `GPT_FREE_MHZ)
`define GPT_FREE_CLR_NS    160
`define GPT_FREE_CLR_CYC   ((`GPT_FREE_CLR_NS * `GPT_CLK_MHZ) / 1000)
`define GPT_TICK_DIV       2500

`endif

// *** include/gpt_pkg.sv ***
package gpt_pkg;

    // Which half of the free-running count the host has taken so far
    typedef enum logic [1:0] {
        GPT_LATCH_IDLE,
        GPT_LATCH_LO_TAKEN,
        GPT_LATCH_HI_TAKEN
    } gpt_latch_t;

endpackage

// *** sim/gp_timer_free_run_word_swap_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gpt_defines.svh"

module gp_timer_free_run_word_swap_tb;
    localparam int TDIV = 2;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        host_cs_n, host_rd_n, host_wr_n;
    logic [7:1]  host_addr;
    logic [15:0] host_data_in, host_data_out, q, p, exp_v;
    logic        host_data_oe, timer_expired, timer_running, swap_on;
    int          err_count = 0, samples_checked = 0, seed = 50;
    int          cyc = 0, since = 0, n;
    logic [31:0] fr;

    gpt_sysctl #(.TICK_DIV(TDIV)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .host_cs_n(host_cs_n),
        .host_rd_n(host_rd_n), .host_wr_n(host_wr_n),
        .host_addr(host_addr), .host_data_in(host_data_in),
        .host_data_out(host_data_out), .host_data_oe(host_data_oe),
        .timer_expired(timer_expired), .timer_running(timer_running),
        .half_swap_active(swap_on));
    gpt_host_model host (
        .core_clk(core_clk), .host_cs_n(host_cs_n), .host_rd_n(host_rd_n),
        .host_wr_n(host_wr_n), .host_addr(host_addr),
        .host_data_in(host_data_in), .host_data_out(host_data_out));

    always #5 core_clk = ~core_clk;

    // Edges since reset release, and a ceiling against hangs
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        since <= rst_n ? since + 1 : 0;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            give_verdict();
        end
    end

    // Free count sampled at the edge that took a read
    function automatic logic [31:0] free_at(input int e);
        return 32'((e - 1) / 4);
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            err_count++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic rd(input logic [7:1] a);
        host.xfer(1'b0, a, 16'h0000, q);
    endtask

    task automatic wr(input logic [7:1] a, input logic [15:0] d);
        host.xfer(1'b1, a, d, q);
    endtask

    // Cycles from one expiry pulse to the next, bounded
    task automatic interval(output int k);
        k = 0;
        while (timer_expired !== 1'b1 && k < 300) begin
            @(negedge core_clk);
            k++;
        end
        k = 0;
        do begin
            @(negedge core_clk);
            k++;
        end while (timer_expired !== 1'b1 && k < 300);
    endtask

    task automatic give_verdict();
        $display("checked=%0d errors=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (16) @(negedge core_clk);
        rd(7'h46); check(q, 16'hffff);
        rd(7'h47); check(q, 16'h0000);
        rd(7'h48); check(q, 16'hffff);
        // Corner preload of zero first, then random small preloads
        for (int i = 0; i < 3; i++) begin
            p = (i == 0) ? 16'h0000 : 16'($random(seed)) & 16'h0007;
            wr(7'h46, p);
            wr(7'h47, 16'h2000); // Enable sits at bit 13 of the upper half
            check({15'h0, timer_running}, 16'h0001);
            interval(n);
            check(16'(n), 16'(4 * TDIV * (p + 1)));
            wr(7'h47, 16'h0000);
            rd(7'h46); check(q, 16'hffff);
        end
        rd(7'h48);
        exp_v = q;
        repeat (20) @(negedge core_clk);
        rd(7'h48); check(q, exp_v);
        wr(7'h4c, 16'hffff);
        wr(7'h4d, 16'hffff);
        check({15'h0, swap_on}, 16'h0001);
        p = 16'($random(seed));
        wr(7'h47, p);
        rd(7'h47); check(q, p);
        rd(7'h46); check(q, 16'h0000);
        wr(7'h4c, 16'h0000); // Lands in the upper half while swapped
        check({15'h0, swap_on}, 16'h0000);
        rd(7'h46); check(q, p);
        rd(7'h4d); check(q, 16'h0000);
        rd(7'h4c); check(q, 16'hffff);
        wr(7'h00, 16'h1234);
        rd(7'h00); check(q, 16'h0000);
        // Upper half first captures; lower half later must match it
        rd(7'h4f);
        n = since;
        fr = free_at(n);
        check(q, fr[31:16]);
        repeat (40) @(negedge core_clk);
        rd(7'h4e); check(q, fr[15:0]);
        rd(7'h4e);
        fr = free_at(since);
        check(q, fr[15:0]);
        give_verdict();
    end
endmodule

`default_nettype wire

// *** sim/gpt_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Host CPU on the register bus; changes lines on falling edges only
module gpt_host_model (
    input  wire logic        core_clk,
    output logic             host_cs_n,
    output logic             host_rd_n,
    output logic             host_wr_n,
    output logic      [7:1]  host_addr,
    output logic      [15:0] host_data_in,
    input  wire logic [15:0] host_data_out
);
    initial begin
        {host_cs_n, host_rd_n, host_wr_n} = 3'b111;
        host_addr = 7'h00;
        host_data_in = 16'h0000;
    end

    // Strobe low across one edge, then released for a full idle edge
    task automatic xfer(input logic wr, input logic [7:1] a,
                        input logic [15:0] d, output logic [15:0] q);
        @(negedge core_clk);
        {host_cs_n, host_rd_n, host_wr_n} = {1'b0, wr, !wr};
        host_addr = a;
        host_data_in = d;
        @(negedge core_clk);
        q = host_data_out;
        {host_cs_n, host_rd_n, host_wr_n} = 3'b111;
        // Released lines must not look like a held value
        host_addr = ~a;
        host_data_in = ~d;
    endtask
endmodule

`default_nettype wire

// *** sim/gpt_sysctl_properties.sv ***
`timescale 1ns/1ps
`default_nettype none

// Port-level checks on the timer, swap and read path
module gpt_sysctl_props #(
    parameter int TICK_DIV = 2500
) (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        host_cs_n,
    input wire logic        host_rd_n,
    input wire logic        host_wr_n,
    input wire logic [7:1]  host_addr,
    input wire logic [15:0] host_data_in,
    input wire logic [15:0] host_data_out,
    input wire logic        host_data_oe,
    input wire logic        timer_expired,
    input wire logic        timer_running,
    input wire logic        half_swap_active
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic rd_on;
    logic wr_on;
    // Strobe levels as the bus sees them
    assign rd_on = !host_cs_n && !host_rd_n;
    assign wr_on = !host_cs_n && !host_wr_n;
    sequence s_halted;
        !timer_running [*8];
    endsequence
    sequence s_pure_wr;
        wr_on && host_rd_n;
    endsequence
    // Spacing of 7 holds for TICK_DIV of 2 and more
    AST_OE_FOLLOWS: assert property (host_data_oe == rd_on)
        else $error("read enable not tied to strobes");
    AST_EXP_ONLY_RUNNING: assert property (
        timer_expired |-> $past(timer_running))
        else $error("expiry while halted");
    AST_HALT_QUIET: assert property (s_halted |-> !timer_expired)
        else $error("halted timer still pulses");
    AST_EXP_SPACING: assert property (
        timer_expired |=> !timer_expired [*7])
        else $error("expiry pulses too close");
    AST_RUN_CAUSE: assert property (
        $changed(timer_running) |-> $past(wr_on))
        else $error("enable moved without a write");
    AST_SWAP_CAUSE: assert property (
        $changed(half_swap_active) |-> $past(wr_on))
        else $error("swap moved without a write");
    AST_DATA_STANDS: assert property (
        $changed(host_data_out) |-> $past(rd_on))
        else $error("read data moved without a read");
    AST_WRITE_KEEPS_DATA: assert property (
        s_pure_wr |=> $stable(host_data_out))
        else $error("write disturbed read data");
    cover property (timer_expired);
endmodule

bind gpt_sysctl gpt_sysctl_props #(.TICK_DIV(TICK_DIV)) u_props (
    .core_clk(core_clk), .rst_n(rst_n), .host_cs_n(host_cs_n),
    .host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .host_addr(host_addr),
    .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .timer_expired(timer_expired),
    .timer_running(timer_running), .half_swap_active(half_swap_active));

`default_nettype wire
